// ### hw/wdt_core.sv
// Watchdog timer with unlock-protected control register on Wishbone.
// Assumes o_wdt_reset feeds the system reset and o_wdt_nmi the core's
// fixed-priority non-maskable interrupt input.
`timescale 1ns/10ps
// Notes on behaviour
// - Codes 0-7 select 15.6-2000 ms; 8 resets
// - Response select turns timeout into interrupt for codes 0-7
// - Watchdog interrupt ignores the global enable
// - Watchdog interrupt priority fixed high
// - Interrupt mode repeats as interval timer
// - Arm bit enables and clears counter
// - Control writes need preceding unlock write
// - Counter advances on slow 32 kHz timebase
module wdt_core
    import wdt_pkg::*;
#(
    parameter int DIV = TB_DIV
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic             o_wb_ack,
    output logic [31:0]      o_wb_dat,
    output logic             o_irq,
    output logic             o_wdt_reset,
    output logic             o_wdt_nmi,
    output logic             o_wdt_nmi_high_priority
);
    typedef struct packed {
        logic            ack;
        logic [31:0]     rdat;
        logic [3:0]      sel;
        logic            irr;
        logic            flag;
        logic            arm;
        logic            unlock;
        logic [CNT_W-1:0] cnt;
        logic [EV_W-1:0] stat;
        logic [EV_W-1:0] mask;
        logic            irq;
        logic            rst;
        logic            nmi;
        logic            prio;
    } wdt_st_t;

    wdt_st_t st_reg;
    wdt_st_t st_next;

    logic             tick;
    logic             commit;
    logic             wr_byte0;
    logic             wr_ctrl;
    logic             ctrl_ok;
    logic             kick;
    logic             tmo;
    logic             tmo_rst;
    logic [CNT_W-1:0] lim;
    logic [7:0]       ctrl_view;
    logic [EV_W-1:0]  ev;

    // ****************************************************************
    // Timebase
    // ****************************************************************
    wdt_tick #(
        .DIV       (DIV)
    ) u_tick (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .o_tick    (tick)
    );

    // ****************************************************************
    // Bus decode and timeout detect
    // ****************************************************************
    assign commit   = i_wb_cyc & i_wb_stb & st_reg.ack;
    assign wr_byte0 = commit & i_wb_we & i_wb_sel[0];
    assign wr_ctrl  = wr_byte0 & (i_wb_adr == ADR_CTRL);
    assign ctrl_ok  = wr_ctrl & st_reg.unlock;
    assign kick     = ctrl_ok & i_wb_dat[CTL_ARM];
    assign lim      = (BASE_TICKS << st_reg.sel[2:0]) - CNT_ONE;
    assign tmo      = st_reg.arm & ~kick &
                      ((st_reg.sel == SEL_IMMED) |
                       (st_reg.sel <= SEL_MAX & tick & st_reg.cnt == lim));
    assign tmo_rst  = tmo & (~st_reg.irr | st_reg.sel == SEL_IMMED);
    assign ctrl_view = {st_reg.sel, st_reg.irr, st_reg.flag,
                        st_reg.arm, st_reg.unlock};

    always_comb begin
        st_next      = st_reg;
        ev           = EV_NONE;
        st_next.ack  = i_wb_cyc & i_wb_stb & ~st_reg.ack;
        st_next.rst  = 1'b0;
        st_next.nmi  = 1'b0;
        st_next.prio = 1'b1;
        if (st_next.ack) begin
            unique case (i_wb_adr)
                ADR_CTRL: st_next.rdat = {24'h000000, ctrl_view};
                ADR_STAT: st_next.rdat = {30'h0, st_reg.stat};
                ADR_MASK: st_next.rdat = {30'h0, st_reg.mask};
                default:  st_next.rdat = 32'h00000000;
            endcase
        end
        // Any access ends the unlock window
        if (commit) begin
            st_next.unlock = 1'b0;
        end
        if (ctrl_ok) begin
            st_next.sel  = i_wb_dat[CTL_SEL_MSB:CTL_SEL_LSB];
            st_next.irr  = i_wb_dat[CTL_IRR];
            st_next.flag = st_reg.flag & i_wb_dat[CTL_FLAG];
            st_next.arm  = i_wb_dat[CTL_ARM];
            if (kick) begin
                st_next.cnt = CNT_ZERO;
            end
        end else if (wr_ctrl & i_wb_dat[CTL_UNL]) begin
            st_next.unlock = 1'b1;
        end else if (wr_ctrl) begin
            ev[EV_REF] = 1'b1;
        end
        if (wr_byte0 & i_wb_adr == ADR_STAT) begin
            st_next.stat = st_reg.stat & ~i_wb_dat[EV_W-1:0];
        end
        if (wr_byte0 & i_wb_adr == ADR_MASK) begin
            st_next.mask = i_wb_dat[EV_W-1:0];
        end
        // Counter only counts up on the slow tick
        if (st_reg.arm & ~kick & tick & st_reg.sel <= SEL_MAX) begin
            st_next.cnt = st_reg.cnt + CNT_ONE;
        end
        if (tmo) begin
            ev[EV_TMO]   = 1'b1;
            st_next.flag = 1'b1;
            st_next.cnt  = CNT_ZERO;
            if (tmo_rst) begin
                st_next.rst = 1'b1;
                st_next.arm = 1'b0;
            end else begin
                st_next.nmi = 1'b1;
            end
        end
        // Hardware events win over a same-cycle clear
        st_next.stat = st_next.stat | ev;
        st_next.irq  = |(st_next.stat & st_next.mask);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_reg      <= '0;
            st_reg.sel  <= SEL_RESET;
            st_reg.prio <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_wb_ack                = st_reg.ack;
    assign o_wb_dat                = st_reg.rdat;
    assign o_irq                   = st_reg.irq;
    assign o_wdt_reset             = st_reg.rst;
    assign o_wdt_nmi               = st_reg.nmi;
    assign o_wdt_nmi_high_priority = st_reg.prio;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    property p_kick_clears;
        kick |=> st_reg.arm && st_reg.cnt == CNT_ZERO;
    endproperty
    a_kick_clears: assert property (p_kick_clears)
        else $error("arm write did not clear counter");

    property p_locked_write;
        wr_ctrl && !st_reg.unlock |=> $stable(st_reg.sel) &&
            $stable(st_reg.irr) && (st_reg.unlock || st_reg.stat[EV_REF]);
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("locked control write was not refused");

    property p_flag_set;
        tmo |=> st_reg.flag && st_reg.stat[EV_TMO];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("timeout did not set status flag");

    property p_irq_mode;
        tmo && st_reg.irr && st_reg.sel != SEL_IMMED |=>
            o_wdt_nmi && !o_wdt_reset;
    endproperty
    a_irq_mode: assert property (p_irq_mode)
        else $error("interrupt mode timeout gave wrong response");

    property p_rst_mode;
        tmo && !st_reg.irr |=> o_wdt_reset && !o_wdt_nmi && !st_reg.arm;
    endproperty
    a_rst_mode: assert property (p_rst_mode)
        else $error("reset mode timeout gave wrong response");

    property p_immediate;
        st_reg.arm && st_reg.sel == SEL_IMMED && !kick |=> o_wdt_reset;
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("code 8 did not reset at once");

    property p_period;
        tmo && st_reg.sel <= SEL_MAX |->
            tick && st_reg.cnt == (BASE_TICKS << st_reg.sel[2:0]) - CNT_ONE;
    endproperty
    a_period: assert property (p_period)
        else $error("timeout at wrong count");

    property p_interval;
        tmo && st_reg.irr && st_reg.sel <= SEL_MAX && !ctrl_ok |=>
            st_reg.arm && st_reg.cnt == CNT_ZERO;
    endproperty
    a_interval: assert property (p_interval)
        else $error("interval timer did not restart");

    property p_slow_count;
        !tick && !kick |=> $stable(st_reg.cnt) || st_reg.cnt == CNT_ZERO;
    endproperty
    a_slow_count: assert property (p_slow_count)
        else $error("counter moved without a tick");

    property p_prio;
        ##1 o_wdt_nmi_high_priority;
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority output dropped");

    c_tmo_reset: cover property (tmo && !st_reg.irr);
    c_tmo_nmi:   cover property (tmo && st_reg.irr ##1 o_wdt_nmi);
    c_refused:   cover property (wr_ctrl && !st_reg.unlock &&
                                 !i_wb_dat[CTL_UNL]);
    c_irq:       cover property (o_irq);
endmodule

// ### hw/wdt_pkg.sv
// Constants, register map and field layout of the watchdog block.
// Assumes a single 250 MHz system clock and a 32-bit Wishbone slave port.
package wdt_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          CLK_HZ      = 250_000_000;
    localparam int          TB_HZ       = 32_768;
    localparam int          TB_DIV      = CLK_HZ / TB_HZ;
    localparam int          TB_W        = 13;
    localparam int          CNT_W       = 17;
    localparam logic [16:0] BASE_TICKS  = 17'h00200;
    localparam logic [16:0] CNT_ONE     = 17'h00001;
    localparam logic [16:0] CNT_ZERO    = 17'h00000;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0]  ADR_CTRL    = 8'h00;
    localparam logic [7:0]  ADR_STAT    = 8'h04;
    localparam logic [7:0]  ADR_MASK    = 8'h08;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int          CTL_SEL_LSB = 4;
    localparam int          CTL_SEL_MSB = 7;
    localparam int          CTL_IRR     = 3;
    localparam int          CTL_FLAG    = 2;
    localparam int          CTL_ARM     = 1;
    localparam int          CTL_UNL     = 0;
    localparam logic [3:0]  SEL_RESET   = 4'h1;
    localparam logic [3:0]  SEL_MAX     = 4'h7;
    localparam logic [3:0]  SEL_IMMED   = 4'h8;

    // ****************************************************************
    // Event status bits
    // ****************************************************************
    localparam int          EV_W        = 2;
    localparam int          EV_TMO      = 0;
    localparam int          EV_REF      = 1;
    localparam logic [1:0]  EV_NONE     = 2'h0;
endpackage

// ### hw/wdt_tick.sv
// Divider that turns the system clock into a one-cycle timebase tick.
// Assumes the division ratio fits in the counter width.
`timescale 1ns/10ps
module wdt_tick
    import wdt_pkg::*;
#(
    parameter int DIV = TB_DIV
) (
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    output logic      o_tick
);
    typedef struct packed {
        logic [TB_W-1:0] cnt;
        logic            tick;
    } wdt_tick_st_t;

    wdt_tick_st_t st_reg;
    wdt_tick_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt == TB_W'(DIV - 1)) begin
            st_next.cnt  = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + TB_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_tick = st_reg.tick;
endmodule

// ### test/wdt_core_tb.sv
// Self-checking bench for the watchdog core and its Wishbone registers.
// Assumes wdt_pkg is compiled first; runs the core with a short divider.
`timescale 1ns/10ps
module wdt_core_tb;
    import wdt_pkg::*;
    localparam int D = 4;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic        ack;
    logic [31:0] rdat;
    logic        irq;
    logic        wrst;
    logic        nmi;
    logic        prio;
    logic [31:0] r;
    logic [3:0]  s;
    int          num_errors = 0;
    int          checks = 0;
    int          cyc_cnt = 0;
    int          rst_cnt = 0;
    int          n;
    int          k;
    int          seed;

    wdt_core #(.DIV(D)) wdt_core_i (
        .i_clk_sys(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_ack(ack), .o_wb_dat(rdat), .o_irq(irq), .o_wdt_reset(wrst),
        .o_wdt_nmi(nmi), .o_wdt_nmi_high_priority(prio)
    );

    // ****************************************************************
    // Clock, hang guard and helpers
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (wrst === 1'b1) rst_cnt <= rst_cnt + 1;
        if (cyc_cnt == 60000) begin
            num_errors++;
            wrap_up();
        end
    end

    task wrap_up;
        if (num_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Period in system clocks for a select code
    function int per(input logic [3:0] c);
        return (512 << c) * D;
    endfunction

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'hf;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Unlock, then the control write itself
    task ctl(input logic [7:0] v);
        wb(1'b1, ADR_CTRL, 32'h01);
        wb(1'b1, ADR_CTRL, {24'h0, v});
    endtask

    task waitp(input logic nm, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while ((nm ? nmi : wrst) !== 1'b1);
    endtask

    task rng(input int c, input int p);
        chk(32'(c >= p - D && c <= p + 2), 32'h1);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 32'hb546dca2;
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(r, 32'h10);
        wb(1'b0, ADR_MASK, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, prio}, 32'h1);
        wb(1'b1, 8'h0c, $random(seed));
        wb(1'b0, 8'h0c, 32'h0);
        chk(r, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h0a);
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(r, 32'h10);
        wb(1'b1, ADR_CTRL, 32'h01);
        wb(1'b0, ADR_STAT, 32'h0);
        chk(r, 32'h2);
        wb(1'b1, ADR_CTRL, 32'h0a);
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(r, 32'h10);
        wb(1'b1, ADR_MASK, 32'h3);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, ADR_STAT, 32'h2);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        s = 4'($unsigned($random(seed)) % 3);
        k = rst_cnt;
        ctl({s, 4'ha});
        waitp(1'b1, n);
        rng(n, per(s));
        waitp(1'b1, n);
        chk(32'(n), 32'(per(s)));
        chk(32'(rst_cnt), 32'(k));
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(r, {24'h0, s, 4'he});
        wb(1'b0, ADR_STAT, 32'h0);
        chk(r & 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, ADR_STAT, 32'h3);
        ctl({s, 4'h2});
        waitp(1'b0, n);
        rng(n, per(s));
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(r, {24'h0, s, 4'h4});
        ctl(8'h02);
        repeat (per(0) / 2) @(posedge clk);
        ctl(8'h02);
        waitp(1'b0, n);
        rng(n, per(0));
        ctl(8'h82);
        waitp(1'b0, n);
        chk(32'(n <= 3), 32'h1);
        ctl(8'h8a);
        waitp(1'b0, n);
        chk(32'(n <= 3), 32'h1);
        ctl(8'h92);
        k = rst_cnt;
        repeat (300) @(posedge clk);
        chk(32'(rst_cnt), 32'(k));
        wrap_up();
    end
endmodule
